// File: mnx_core.sv
// Execution unit for multiply, negate, stack pop/push, relative call
// and software reset. Registers are reached over Avalon-MM; a
// small internal file memory stands in for the data space.
// Assumes one instruction at a time, issued via the INSTR register.
//
// Overview of operation
// - Literal multiply: accumulator times 8-bit literal, unsigned.
// - Literal product: 16 bits to high/low bytes; accumulator kept.
// - File multiply: accumulator times addressed file, both kept.
// - File product goes to the product pair, high byte in high.
// - Multiplies change no status flag; zero product is not flagged.
// - Bank bit 0 picks access bank; 1 uses bank selector.
// - Bank bit 0 with extended set: address up to 95 is indexed.
// - Negate writes two's complement of the file back to it.
// - Negate updates N, sign wrap, carry, half carry and zero.
// - Pop discards top entry; the entry below becomes top.
// - Push places PC plus 2 on the stack as new top.
// - Relative call carries 11-bit signed word offset in low bits.
// - Relative call pushes PC+2 then jumps to PC+2+2n; two cycles.
// - Software reset restores every register as external reset does, but not avs_readdata or avs_waitrequest.
module mnx_core #(
  parameter int FILE_WORDS = 256
) (
  input  wire logic        clk_i,                 // Core clock
  input  wire logic        rst_i,                 // Sync reset
  input  wire logic [3:0]  avs_address,           // Word index
  input  wire logic        avs_read,              // Read strobe
  input  wire logic        avs_write,             // Write strobe
  input  wire logic [31:0] avs_writedata,         // Write data
  input  wire logic [3:0]  avs_byteenable,        // Byte lanes
  output logic      [31:0] avs_readdata,          // Read data
  output logic             avs_waitrequest,       // Stall
  output logic             busy_o,                // Executing
  output logic      [20:0] pc_o,                  // Program counter
  output logic      [7:0]  product_high_byte_o,   // Product high
  output logic      [7:0]  product_low_byte_o     // Product low
);
  import mnx_pkg::*;

  mnx_state_t  state;
  logic [1:0]  qph;
  logic [15:0] instr;
  logic [7:0]  acc;
  logic [4:0]  status;
  logic [3:0]  bank_selector;
  logic        ext_en;
  logic [7:0]  idx_base;
  logic [7:0]  fmem [FILE_WORDS];
  logic [7:0]  fptr;
  logic        soft_rst;
  logic        rst_all;
  logic [15:0] prod;
  logic [7:0]  neg;
  logic [4:0]  nflg;
  logic [7:0]  faddr;
  logic [7:0]  fval;
  logic        st_push;
  logic        st_pop;
  logic [20:0] stack_top_entry;
  logic [4:0]  depth;
  logic        is_mul_lit;
  logic        is_mul_file;
  logic        is_neg_file;
  logic        is_pop;
  logic        is_push;
  logic        is_rel_call;
  logic        is_reset;
  logic        wr_instr;
  logic [20:0] next_pc;

  ////////////////////////////////////////////////////////////////
  // Decode of the latched instruction word
  assign is_mul_lit  = (instr[15:8] == OPC_MUL_LIT);
  assign is_mul_file = (instr[15:9] == OPC_MUL_FILE);
  assign is_neg_file = (instr[15:9] == OPC_NEG_FILE);
  assign is_pop      = (instr == OPC_POP);
  assign is_push     = (instr == OPC_PUSH);
  assign is_rel_call = (instr[15:11] == OPC_REL_CALL);
  assign is_reset    = (instr == OPC_RESET);

  // Effective file address; banks are 16 bytes here as the memory
  // is small, the upper access half maps to the top bank
  always_comb
  begin
    faddr = instr[7:0];
    if (!instr[8])
    begin
      if (ext_en && instr[7:0] <= IDX_LIMIT)
        faddr = idx_base + instr[7:0];
      else if (instr[7:0] >= ACCESS_SPLIT)
        faddr = {ACCESS_HI_BK, instr[3:0]};
      else
        faddr = instr[7:0];
    end
    else
      faddr = {bank_selector, instr[3:0]};
  end
  assign fval = fmem[faddr];

  mnx_alu u_alu (
    .a_i    (acc),
    .b_i    (is_mul_lit ? instr[7:0] : fval),
    .prod_o (prod),
    .neg_o  (neg),
    .flg_o  (nflg)
  );

  // Pushes come from the push op or the first call cycle
  assign st_push = (state == MNX_EXEC) && (qph == Q_LAST)
                   && (is_push || is_rel_call);
  assign st_pop  = (state == MNX_EXEC) && (qph == Q_LAST)
                   && is_pop;

  mnx_stack u_stack (
    .clk_i   (clk_i),
    .rst_i   (rst_all),
    .push_i  (st_push),
    .pop_i   (st_pop),
    .data_i  (pc_o + PC_STEP),
    .top_o   (stack_top_entry),
    .depth_o (depth)
  );

  assign soft_rst = (state == MNX_EXEC) && is_reset;
  assign rst_all  = rst_i || soft_rst;
  assign wr_instr = avs_write && !avs_waitrequest
                    && avs_address == ADDR_INSTR && state == MNX_IDLE;

  ////////////////////////////////////////////////////////////////
  // Sequencer: four quarter phases per instruction cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      state <= MNX_IDLE;
      qph   <= 2'h0;
      instr <= 16'h0000;
    end
    else
      case (state)
        MNX_IDLE:
          if (wr_instr)
          begin
            instr <= avs_writedata[15:0];
            qph   <= 2'h0;
            state <= MNX_EXEC;
          end
        MNX_EXEC:
        begin
          qph <= qph + 2'h1;
          if (qph == Q_LAST)
            state <= is_rel_call ? MNX_CALL2 : MNX_DONE;
        end
        MNX_CALL2:
        begin
          qph <= qph + 2'h1;
          if (qph == Q_LAST)
            state <= MNX_DONE;
        end
        MNX_DONE:
          state <= MNX_IDLE;
        default:
          state <= MNX_IDLE;
      endcase
  end

  // Program counter: call target is PC+2+2n, else PC+2 per op
  always_comb
  begin
    next_pc = pc_o + PC_STEP;
    if (is_rel_call)
      next_pc = pc_o + PC_STEP + {{9{instr[10]}}, instr[10:0], 1'b0};
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      pc_o <= PC_RST;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_PC
             && state == MNX_IDLE)
      pc_o <= {avs_writedata[20:1], 1'b0};
    else if (state == MNX_EXEC && qph == Q_LAST)
      pc_o <= next_pc;
  end

  // Product pair, written only in the last quarter
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      product_high_byte_o <= BYTE_RST;
      product_low_byte_o  <= BYTE_RST;
    end
    else if (state == MNX_EXEC && qph == Q_LAST
             && (is_mul_lit || is_mul_file))
    begin
      product_high_byte_o <= prod[15:8];
      product_low_byte_o  <= prod[7:0];
    end
  end

  // Status flags: only negate touches them; multiplies do not
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      status <= 5'h00;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_STATUS
             && state == MNX_IDLE)
      status <= avs_writedata[4:0];
    else if (state == MNX_EXEC && qph == Q_LAST && is_neg_file)
      status <= nflg;
  end

  // Software-owned operand and mode registers
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      acc           <= BYTE_RST;
      bank_selector <= 4'h0;
      ext_en        <= 1'b0;
      idx_base      <= BYTE_RST;
      fptr          <= BYTE_RST;
    end
    else if (avs_write && !avs_waitrequest && state == MNX_IDLE)
      case (avs_address)
        ADDR_ACC:   acc           <= avs_writedata[7:0];
        ADDR_BANK:  bank_selector <= avs_writedata[3:0];
        ADDR_CTRL:
        begin
          ext_en   <= avs_writedata[0];
          idx_base <= avs_writedata[15:8];
        end
        ADDR_FADDR: fptr          <= avs_writedata[7:0];
        default:    fptr          <= fptr;
      endcase
  end

  // File memory; negate writes back to the same location
  always_ff @(posedge clk_i)
  begin
    if (state == MNX_EXEC && qph == Q_LAST && is_neg_file)
      fmem[faddr] <= neg;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_FDATA
             && state == MNX_IDLE && avs_byteenable[0])
      fmem[fptr] <= avs_writedata[7:0];
  end

  ////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, stalls while executing
  // Stall kept in a flop so the bus never sees decode glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest
                           && state == MNX_IDLE);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      avs_readdata <= 32'h00000000;
    else
      case (avs_address)
        ADDR_CTRL:   avs_readdata <= {16'h0000, idx_base, 7'h00, ext_en};
        ADDR_INSTR:  avs_readdata <= {16'h0000, instr};
        ADDR_PC:     avs_readdata <= {11'h000, pc_o};
        ADDR_ACC:    avs_readdata <= {24'h000000, acc};
        ADDR_PROD:   avs_readdata <= {16'h0000, product_high_byte_o,
                                      product_low_byte_o};
        ADDR_STATUS: avs_readdata <= {27'h0000000, status};
        ADDR_BANK:   avs_readdata <= {28'h0000000, bank_selector};
        ADDR_STK_TOP: avs_readdata <= {11'h000, stack_top_entry};
        ADDR_FADDR:  avs_readdata <= {24'h000000, fptr};
        ADDR_FDATA:  avs_readdata <= {24'h000000, fmem[fptr]};
        ADDR_DEPTH:  avs_readdata <= {27'h0000000, depth};
        default:     avs_readdata <= 32'h00000000;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      busy_o <= 1'b0;
    else
      busy_o <= (state != MNX_IDLE) || wr_instr;
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  chk_prod_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && qph == Q_LAST && is_mul_lit && !soft_rst)
      |=> ({product_high_byte_o, product_low_byte_o}
           == $past(acc) * $past(instr[7:0])))
    else $error("literal product wrong");
  chk_acc_kept: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && (is_mul_lit || is_mul_file)) |=> $stable(acc))
    else $error("accumulator changed by multiply");
  chk_mul_flags: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && (is_mul_lit || is_mul_file))
      |=> $stable(status))
    else $error("multiply changed flags");
  chk_call_two: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && qph == 2'h0 && is_rel_call)
      |-> ##4 (state == MNX_CALL2) ##4 (state == MNX_DONE))
    else $error("call not two cycles");
  chk_push_top: assert property (@(posedge clk_i)
    disable iff (rst_i)
    st_push |=> (stack_top_entry == $past(pc_o) + PC_STEP))
    else $error("push value wrong");
  chk_neg_flag: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && qph == Q_LAST && is_neg_file)
      |=> (status[ST_Z] == ($past(fval) == 8'h00)
           && status[ST_C] == ($past(fval) == 8'h00)))
    else $error("negate zero or carry flag wrong");
  chk_one_cycle: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state == MNX_EXEC && qph == 2'h0 && !is_rel_call && !is_reset)
      |-> ##4 (state == MNX_DONE))
    else $error("single op not one cycle");
  chk_soft_reset: assert property (@(posedge clk_i)
    disable iff (rst_i)
    soft_rst |=> (pc_o == PC_RST && acc == BYTE_RST && status == 5'h00))
    else $error("software reset incomplete");
endmodule

// File: mnx_pkg.sv
// Package for the multiply/negate/stack/call execution block.
// Assumes a single core clock and a synchronous active-high reset.
package mnx_pkg;
  // Register map (word index = byte address / 4)
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_INSTR   = 4'h1;
  localparam logic [3:0]  ADDR_PC      = 4'h2;
  localparam logic [3:0]  ADDR_ACC     = 4'h3;
  localparam logic [3:0]  ADDR_PROD    = 4'h4;
  localparam logic [3:0]  ADDR_STATUS  = 4'h5;
  localparam logic [3:0]  ADDR_BANK    = 4'h6;
  localparam logic [3:0]  ADDR_STK_TOP = 4'h7;
  localparam logic [3:0]  ADDR_FADDR   = 4'h8;
  localparam logic [3:0]  ADDR_FDATA   = 4'h9;
  localparam logic [3:0]  ADDR_DEPTH   = 4'hA;
  // Opcode patterns
  localparam logic [7:0]  OPC_MUL_LIT  = 8'h0D;
  localparam logic [6:0]  OPC_MUL_FILE = 7'h01;
  localparam logic [6:0]  OPC_NEG_FILE = 7'h36;
  localparam logic [15:0] OPC_POP      = 16'h0006;
  localparam logic [15:0] OPC_PUSH     = 16'h0005;
  localparam logic [4:0]  OPC_REL_CALL = 5'h1B;
  localparam logic [15:0] OPC_RESET    = 16'h00FF;
  // Addressing
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BK = 4'hF;
  // Status bit positions
  localparam int          ST_C  = 0;
  localparam int          ST_HC = 1;
  localparam int          ST_Z  = 2;
  localparam int          ST_SW = 3;
  localparam int          ST_N  = 4;
  // Reset values, last quarter phase and PC step
  localparam logic [20:0] PC_RST       = 21'h000000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [1:0]  Q_LAST       = 2'h3;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  typedef enum logic [3:0] {
    MNX_IDLE  = 4'b0001,
    MNX_EXEC  = 4'b0010,
    MNX_CALL2 = 4'b0100,
    MNX_DONE  = 4'b1000
  } mnx_state_t;
endpackage

// File: mnx_stack.sv
// Return stack: push/pop of 21-bit addresses, top kept in a register.
// Assumes callers never push and pop in the same cycle.
module mnx_stack #(
  parameter int DEPTH = 31,
  parameter int AW    = 21
) (
  input  wire logic          clk_i,  // Core clock
  input  wire logic          rst_i,  // Sync reset
  input  wire logic          push_i, // Push value
  input  wire logic          pop_i,  // Pop and discard
  input  wire logic [AW-1:0] data_i, // Value to push
  output logic      [AW-1:0] top_o,  // Current top entry
  output logic      [4:0]    depth_o // Entries held
);
  import mnx_pkg::*;
  logic [AW-1:0] mem [DEPTH];
  ////////////////////////////////////////////////////////////////
  // Shift register stack, one generate stage per level
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_lvl
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        mem[g] <= '0;
      else if (push_i)
        mem[g] <= (g == 0) ? data_i : mem[(g == 0) ? 0 : g - 1];
      else if (pop_i)
        mem[g] <= (g == DEPTH - 1) ? '0 : mem[(g == DEPTH - 1) ? g : g + 1];
    end
  end
  // Depth count saturates; overflow silently loses the oldest entry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      depth_o <= 5'h00;
    else if (push_i && depth_o != 5'(DEPTH))
      depth_o <= depth_o + 5'h01;
    else if (pop_i && depth_o != 5'h00)
      depth_o <= depth_o - 5'h01;
  end
  assign top_o = mem[0];
endmodule

// File: mnx_alu.sv
// Combinational multiply and negate datapath.
// Pure logic; results are registered by the caller.
module mnx_alu (
  input  wire logic [7:0]  a_i,    // Accumulator operand
  input  wire logic [7:0]  b_i,    // Literal or file operand
  output logic      [15:0] prod_o, // Unsigned product
  output logic      [7:0]  neg_o,  // Two's complement of b
  output logic      [4:0]  flg_o   // N SW Z HC C of negate
);
  import mnx_pkg::*;
  logic [8:0] sum;
  logic [4:0] hsum;
  // Unsigned 8x8 product, no flags derived
  assign prod_o = 16'(a_i) * 16'(b_i);
  // Negate as ~b + 1 so carry and half carry follow the adder
  assign sum    = {1'b0, ~b_i} + 9'h001;
  assign hsum   = {1'b0, ~b_i[3:0]} + 5'h01;
  assign neg_o  = sum[7:0];
  always_comb
  begin
    flg_o        = 5'h00;
    flg_o[ST_C]  = sum[8];
    flg_o[ST_HC] = hsum[4];
    flg_o[ST_Z]  = (sum[7:0] == 8'h00);
    flg_o[ST_SW] = (b_i == 8'h80);
    flg_o[ST_N]  = sum[7];
  end
endmodule

// File: tb_top.sv
// Self-checking bench for the multiply/negate/stack/call unit.
// Assumes the unit is reached only over its Avalon-MM slave port.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mnx_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy_o;
  logic [20:0] pc_o;
  logic [7:0]  product_high_byte_o;
  logic [7:0]  product_low_byte_o;
  logic [31:0] rd;
  logic [20:0] exp_pc;
  int          err_count;
  int          num_checks;
  int          cyc;
  int          mul_cyc;

  mnx_core uut (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .busy_o              (busy_o),
    .pc_o                (pc_o),
    .product_high_byte_o (product_high_byte_o),
    .product_low_byte_o  (product_low_byte_o)
  );

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge clk_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Issue one opcode, wait out busy, compare the new program counter
  task automatic exec(input logic [15:0] op, input logic [20:0] npc);
    bus(ADDR_INSTR, 1'b1, {16'h0000, op});
    for (int i = 0; i < 4 && busy_o !== 1'b1; i++) @(posedge clk_i);
    cyc = 0;
    while (busy_o === 1'b1 && cyc < 50)
    begin
      @(posedge clk_i);
      cyc++;
    end
    @(posedge clk_i);
    chk("pc", {11'h000, pc_o}, {11'h000, npc});
    exp_pc = npc;
  endtask

  task automatic set_file(input logic [7:0] adr, input logic [7:0] v);
    bus(ADDR_FADDR, 1'b1, {24'h000000, adr});
    bus(ADDR_FDATA, 1'b1, {24'h000000, v});
  endtask

  task automatic rd_file(input logic [7:0] adr);
    bus(ADDR_FADDR, 1'b1, {24'h000000, adr});
    bus(ADDR_FDATA, 1'b0, 32'h00000000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expected file address for bank bit, selector and indexed mode
  function automatic logic [7:0] fmap(logic a, logic [7:0] f,
      logic [3:0] bk, logic ext, logic [7:0] base);
    if (a)
      return {bk, f[3:0]};
    else if (ext && f <= IDX_LIMIT)
      return base + f;
    else if (f >= ACCESS_SPLIT)
      return {ACCESS_HI_BK, f[3:0]};
    else
      return f;
  endfunction

  // Negate flags, packed as N, sign wrap, Z, half carry, C
  function automatic logic [4:0] nflags(logic [7:0] v);
    logic [7:0] r;
    r = ~v + 8'h01;
    return {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: far above the roughly 1400 cycles the sequence needs
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    logic [7:0]  acc, k, f, v, adr, base;
    logic [4:0]  st;
    logic [3:0]  bk;
    logic        a, ext;
    logic [10:0] n;
    logic [20:0] t1, t2;
    clk_i = 1'b0;
    rst_i = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    err_count = 0;
    num_checks = 0;
    exp_pc = PC_RST;
    void'($urandom(24));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Unmapped index: write dropped, read returns zero
    bus(4'hB, 1'b1, 32'hFFFFFFFF);
    bus(4'hB, 0, 0);
    chk("unmapped", rd, 32'h00000000);
    // Literal multiply, corners first then random
    for (int i = 0; i < 10; i++)
    begin
      acc = (i == 0) ? 8'hE2 : (i == 1) ? 8'hFF : 8'($urandom);
      k = (i == 0) ? 8'hC4 : (i == 1) ? 8'hFF : (i == 2) ? 8'h00
        : 8'($urandom);
      st = 5'($urandom);
      bus(ADDR_ACC, 1, {24'h0, acc});
      bus(ADDR_STATUS, 1, {27'h0, st});
      exec({OPC_MUL_LIT, k}, exp_pc + PC_STEP);
      mul_cyc = cyc;
      chk("prod_pins", {16'h0, product_high_byte_o, product_low_byte_o},
          {16'h0, 16'(acc) * 16'(k)});
      bus(ADDR_PROD, 0, 0);
      chk("prod_reg", rd, {16'h0, 16'(acc) * 16'(k)});
      bus(ADDR_ACC, 0, 0);
      chk("acc_kept", rd, {24'h0, acc});
      bus(ADDR_STATUS, 0, 0);
      chk("status_mul", rd, {27'h0, st});
    end
    // File multiply through both bank sources
    for (int i = 0; i < 10; i++)
    begin
      a = i[0];
      bk = 4'($urandom);
      f = {a, 7'($urandom)};
      acc = (i == 2) ? 8'h00 : 8'($urandom);
      v = (i == 3) ? 8'hB5 : 8'($urandom);
      st = 5'($urandom);
      adr = fmap(a, f, bk, 1'b0, 8'h00);
      bus(ADDR_BANK, 1, {28'h0, bk});
      set_file(adr, v);
      bus(ADDR_ACC, 1, {24'h0, acc});
      bus(ADDR_STATUS, 1, {27'h0, st});
      exec({OPC_MUL_FILE, a, f}, exp_pc + PC_STEP);
      bus(ADDR_PROD, 0, 0);
      chk("prod_file", rd, {16'h0, 16'(acc) * 16'(v)});
      rd_file(adr);
      chk("file_kept", rd, {24'h0, v});
      bus(ADDR_ACC, 0, 0);
      chk("acc_kept_f", rd, {24'h0, acc});
      bus(ADDR_STATUS, 0, 0);
      chk("status_mulf", rd, {27'h0, st});
    end
    // Negate in direct, banked and indexed modes; edge values 00 and 80
    base = 8'h90;
    for (int i = 0; i < 16; i++)
    begin
      ext = (i >= 8);
      a = (i == 8 || i == 9) ? 1'b0 : i[0];
      f = (i == 8) ? IDX_LIMIT : (i == 9) ? 8'h60 : 8'($urandom);
      v = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h80 : 8'($urandom);
      bk = 4'($urandom);
      adr = fmap(a, f, bk, ext, base);
      bus(ADDR_CTRL, 1, {16'h0, base, 7'h0, ext});
      bus(ADDR_BANK, 1, {28'h0, bk});
      set_file(adr, v);
      exec({OPC_NEG_FILE, a, f}, exp_pc + PC_STEP);
      rd_file(adr);
      chk("neg_val", rd, {24'h0, ~v + 8'h01});
      bus(ADDR_STATUS, 0, 0);
      chk("neg_flags", rd, {27'h0, nflags(v)});
    end
    // Push twice, pop twice
    t1 = exp_pc + PC_STEP;
    exec(OPC_PUSH, t1);
    t2 = exp_pc + PC_STEP;
    exec(OPC_PUSH, t2);
    bus(ADDR_STK_TOP, 0, 0);
    chk("top_push", rd, {11'h0, t2});
    bus(ADDR_DEPTH, 0, 0);
    chk("depth_push", rd, 32'h2);
    exec(OPC_POP, exp_pc + PC_STEP);
    bus(ADDR_STK_TOP, 0, 0);
    chk("top_pop", rd, {11'h0, t1});
    exec(OPC_POP, exp_pc + PC_STEP);
    bus(ADDR_DEPTH, 0, 0);
    chk("depth_pop", rd, 32'h0);
    // Load the program counter near the top so a call wraps around
    bus(ADDR_PC, 1, 32'h001FFFFE);
    exp_pc = 21'h1FFFFE;
    // Relative call at both ends of the offset range and at random
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 11'h3FF : (i == 1) ? 11'h400 : (i == 2) ? 11'h000
        : 11'($urandom);
      t1 = exp_pc + PC_STEP;
      exec({OPC_REL_CALL, n}, t1 + {{9{n[10]}}, n, 1'b0});
      chk("call_len", cyc, mul_cyc + 4);
      bus(ADDR_STK_TOP, 0, 0);
      chk("top_call", rd, {11'h0, t1});
    end
    // Software reset brings the visible state back to its reset values
    bus(ADDR_ACC, 1, 32'h5A);
    bus(ADDR_BANK, 1, 32'h7);
    bus(ADDR_STATUS, 1, 32'h1F);
    bus(ADDR_CTRL, 1, 32'h1001);
    exec(OPC_RESET, PC_RST);
    for (int j = 0; j < 11; j++)
    begin
      if (j == 1 || j == 7 || j == 8 || j == 9)
        continue;
      bus(4'(j), 0, 0);
      chk("reg_after_reset", rd, 32'h0);
    end
    chk("prod_pins_rst", {16'h0, product_high_byte_o, product_low_byte_o},
        32'h0);
    finish_test();
  end
endmodule
